// [dv/adcct_host.sv]
// Host serial port model: control writes, result reads.
`timescale 1ns/1ps
`default_nettype none
module adcct_host (
   // Mode and lines the host listens to.
   input  wire logic mode,
   input  wire logic sclk_line,
   input  wire logic rfs_line,
   input  wire logic sdo,
   // Lines the host drives.
   output var  logic tfs_n,
   output var  logic sdi,
   output var  logic hclk,
   output var  logic hrfs_n
);
   logic smp;
   // Frames idle high and the host clock parks high.
   initial begin
      tfs_n = 1'b1;
      sdi = 1'b0;
      hclk = 1'b1;
      hrfs_n = 1'b1;
   end
   // One serial clock: data is taken on the fall in self mode and at the end of the low phase in external mode, moved on the rise.
   task automatic tick();
      if (mode) begin
         #100 hclk <= 1'b0;
         #100 smp = sdo;
         hclk <= 1'b1;
      end else begin
         @(negedge sclk_line);
         smp = sdo;
         @(posedge sclk_line);
      end
   endtask : tick
   // Five control bits and one ignored bit, so six clocks load the word.
   task automatic write_ctrl(input logic [4:0] w);
      tfs_n <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         sdi <= (i < 5) ? w[4-i] : ~sdi;
         tick();
      end
      tfs_n <= 1'b1;
      sdi <= ~sdi;
   endtask : write_ctrl
   // Sixteen result bits, first bit first.
   task automatic read_frame(output logic [15:0] f);
      if (!mode) wait (rfs_line == 1'b0);
      hrfs_n <= ~mode;
      for (int i = 15; i >= 0; i--) begin
         tick();
         f[i] = smp;
      end
      #100 hrfs_n <= 1'b1;
      #100;
   endtask : read_frame
endmodule : adcct_host
`default_nettype wire

// [dv/adcct_top_sva.sv]
// Concurrent checks on the conversion and link pins.
`timescale 1ns/1ps
`default_nettype none
module adcct_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Pins and converter core.
   input wire logic interface_mode_select,
   input wire logic convert_start_n,
   input wire logic transmit_frame_sync_n,
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe,
   input wire logic receive_frame_sync_n_out,
   input wire logic receive_frame_sync_n_oe,
   input wire logic track_hold,
   input wire logic standby,
   input wire logic settle_active
);
   logic [5:0] hold_cnt;
   logic [5:0] next_hold_cnt;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // Counts cycles spent in hold.
   always_comb next_hold_cnt = track_hold ? hold_cnt + 6'h01 : 6'h00;
   // Registers the hold count.
   always_ff @(posedge clock) hold_cnt <= srst ? 6'h00 : next_hold_cnt;
   a_hold_run:
      assert property (track_hold && hold_cnt < 6'h1C |=> track_hold)
      else $error("hold ended early");
   a_hold_end:
      assert property (track_hold && hold_cnt == 6'h1C |=> !track_hold)
      else $error("hold ran too long");
   a_frame_start:
      assert property ($fell(track_hold) && !interface_mode_select
         |-> ##[0:2] !receive_frame_sync_n_out)
      else $error("frame sync late after conversion");
   a_ext_silent:
      assert property (interface_mode_select
         |-> !serial_clock_oe && !receive_frame_sync_n_oe)
      else $error("external mode drives link lines");
   a_sclk_high:
      assert property ($rose(serial_clock_out) |=> serial_clock_out)
      else $error("serial clock high phase short");
   a_sclk_low:
      assert property ($fell(serial_clock_out)
         |=> !serial_clock_out ##1 serial_clock_out)
      else $error("serial clock low phase wrong");
   a_start_hold:
      assert property ($rose(convert_start_n) && !track_hold && !standby
         && !settle_active && receive_frame_sync_n_out
         |-> ##[1:5] track_hold)
      else $error("start edge did not hold");
   a_settle_gate:
      assert property ($rose(track_hold) |-> !settle_active)
      else $error("hold began during settling");
   a_settle_rise:
      assert property ($fell(transmit_frame_sync_n) |-> ##[1:5] settle_active)
      else $error("write did not start settling");
endmodule : adcct_chk
bind adcct_top adcct_chk adcct_chk_inst (
   .clock, .srst, .interface_mode_select, .convert_start_n,
   .transmit_frame_sync_n, .serial_clock_out, .serial_clock_oe,
   .receive_frame_sync_n_out, .receive_frame_sync_n_oe, .track_hold,
   .standby, .settle_active
);
`default_nettype wire

// [dv/adcct_top_tb.sv]
// Self-checking bench for the converter timing and control block.
`timescale 1ns/1ps
`default_nettype none
module adcct_top_tb;
   logic        clock, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, hclk, hrfs_n;
   logic        interface_mode_select, convert_start_n, serial_data_in;
   logic        transmit_frame_sync_n, sclk_line, rfs_line, standby;
   logic        serial_clock_out, serial_clock_oe, serial_data_out;
   logic        receive_frame_sync_n_out, receive_frame_sync_n_oe;
   logic        serial_data_oe, track_hold, settle_active;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [11:0] conversion_code;
   logic [2:0]  mux_channel;
   int          err_total, cmp_count;
   // Wire levels of the two-way link lines.
   assign sclk_line = serial_clock_oe ? serial_clock_out : hclk;
   assign rfs_line = receive_frame_sync_n_oe ? receive_frame_sync_n_out
                                              : hrfs_n;
   adcct_top adcct_top_inst (
      .clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .interface_mode_select,
      .convert_start_n, .transmit_frame_sync_n, .serial_data_in,
      .serial_clock_in(sclk_line), .serial_clock_out, .serial_clock_oe,
      .receive_frame_sync_n_in(rfs_line), .receive_frame_sync_n_out,
      .receive_frame_sync_n_oe, .serial_data_out, .serial_data_oe,
      .conversion_code, .track_hold, .mux_channel, .standby, .settle_active
   );
   adcct_host adcct_host_inst (
      .mode(interface_mode_select), .sclk_line, .rfs_line,
      .sdo(serial_data_out), .tfs_n(transmit_frame_sync_n),
      .sdi(serial_data_in), .hclk, .hrfs_n
   );
   // Free-running bench clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // Bus write: address and data held until their ready is seen at an edge, bready until the response comes.
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic pa, pw, pb, ga, gw, gb;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      {pa, pw, pb} = 3'h7;
      while (pb) begin
         @(negedge clock);
         ga = pa && s_axi_awready;
         gw = pw && s_axi_wready;
         gb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (ga) s_axi_awvalid <= 1'b0;
         if (gw) s_axi_wvalid <= 1'b0;
         if (gb) s_axi_bready <= 1'b0;
         {pa, pw, pb} = {pa && !ga, pw && !gw, !gb};
      end
   endtask : axi_wr
   // Bus read: address held until taken, rready until data comes.
   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic pa, pr, ga, gr;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      {pa, pr} = 2'h3;
      while (pr) begin
         @(negedge clock);
         ga = pa && s_axi_arready;
         gr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ga) s_axi_arvalid <= 1'b0;
         if (gr) s_axi_rready <= 1'b0;
         {pa, pr} = {pa && !ga, !gr};
      end
   endtask : axi_rd
   task automatic do_reset(input logic m);
      @(posedge clock);
      srst <= 1'b1;
      interface_mode_select <= m;
      cyc(8);
      srst <= 1'b0;
      cyc(3);
   endtask : do_reset
   // Settle length register and unmapped offsets.
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(5'h04, d, r);
      check("settle_rst", {16'h0000, d[15:0]}, 32'h00000050);
      axi_rd(5'h10, d, r);
      check("rd_unmapped", {30'h0, r}, {30'h0, adcct_pkg::RESP_SLVERR});
      axi_wr(5'h14, 32'h00000001, r);
      check("wr_unmapped", {30'h0, r}, {30'h0, adcct_pkg::RESP_SLVERR});
      axi_wr(5'h04, 32'h00000028, r);
      axi_rd(5'h04, d, r);
      check("settle_len", {16'h0000, d[15:0]}, 32'h00000028);
   endtask : t_regs
   // Self clocking: channel write, hardware start, conversion time, frame read.
   task automatic t_self();
      logic [15:0] f;
      int          n;
      conversion_code <= 12'hA5C;
      adcct_host_inst.write_ctrl(5'h14);
      cyc(6);
      @(negedge clock);
      check("mux_self", {29'h0, mux_channel}, 32'h00000005);
      check("settle_on", {31'h0, settle_active}, 32'h00000001);
      cyc(80);
      convert_start_n <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         convert_start_n <= (n != 10);
         n++;
         @(negedge clock);
      end while (receive_frame_sync_n_out);
      check("soft_convert_bit_time", {31'h0, n <= adcct_pkg::SOFT_CONVERT_BIT_MAX_CLKS}, 32'h1);
      adcct_host_inst.read_frame(f);
      check("frame_self", {16'h0, f}, {17'h0, 3'h5, 12'hA5C});
      cyc(2);
      @(negedge clock);
      check("rfs_end", {30'h0, receive_frame_sync_n_out, serial_data_oe},
            32'h2);
   endtask : t_self
   // External clocking: soft start waits out the settling pulse.
   task automatic t_soft();
      logic [15:0] f;
      int          n;
      conversion_code <= 12'h5A3;
      adcct_host_inst.write_ctrl(5'h0E);
      @(negedge clock);
      check("soft_wait", {31'h0, track_hold}, 32'h0);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (!track_hold && n < 200);
      check("soft_delay", {31'h0, n > 70 && n < 100}, 32'h1);
      cyc(adcct_pkg::SOFT_CONVERT_BIT_MAX_CLKS);
      adcct_host_inst.read_frame(f);
      check("frame_soft", {16'h0, f}, {17'h0, 3'h3, 12'h5A3});
   endtask : t_soft
   // External clocking: square wave start, read twice after the fall.
   task automatic t_ext_hw();
      logic [15:0] f;
      conversion_code <= 12'h3C1;
      @(posedge clock);
      convert_start_n <= 1'b0;
      cyc(40);
      convert_start_n <= 1'b1;
      cyc(adcct_pkg::SOFT_CONVERT_BIT_MAX_CLKS);
      convert_start_n <= 1'b0;
      adcct_host_inst.read_frame(f);
      check("frame_ext", {16'h0, f}, {17'h0, 3'h3, 12'h3C1});
      adcct_host_inst.read_frame(f);
      check("frame_again", {16'h0, f}, {17'h0, 3'h3, 12'h3C1});
   endtask : t_ext_hw
   // Main sequence: self clocking first, then external clocking.
   initial begin
      {srst, interface_mode_select, convert_start_n} = 3'h5;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr} = 10'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      conversion_code = 12'h000;
      {err_total, cmp_count} = 64'h0;
      do_reset(1'b0);
      t_regs();
      t_self();
      do_reset(1'b1);
      t_soft();
      t_ext_hw();
      wrap_up();
   end
   // Cuts a hung run short.
   initial begin
      cyc(6000);
      err_total++;
      wrap_up();
   end
endmodule : adcct_top_tb
`default_nettype wire

// [src/adcct_pkg.sv]
// Shared constants for the converter timing and control block.
package adcct_pkg;
   // Clock and timing.
   localparam int CLOCK_MHZ        = 40;
   localparam int MCLK_DIV         = 2;
   localparam int SOFT_CONVERT_BIT_MCLK_HALVES = 29;
   localparam int SOFT_CONVERT_BIT_CLKS        = SOFT_CONVERT_BIT_MCLK_HALVES * MCLK_DIV / 2;
   localparam int SCLK_HALF_CLKS   = 2;
   localparam int SOFT_CONVERT_BIT_MAX_NS      = 5900;
   localparam int SOFT_CONVERT_BIT_MAX_CLKS    = SOFT_CONVERT_BIT_MAX_NS * CLOCK_MHZ / 1000;
   localparam int SETTLE_NS        = 2000;
   localparam int SETTLE_CLKS      = (SETTLE_NS * CLOCK_MHZ + 999) / 1000;
   // Serial framing.
   localparam int CTRL_BITS        = 5;
   localparam int WR_LOAD_FALL     = 6;
   localparam int FRAME_BITS       = 16;
   localparam int RESULT_BITS      = 12;
   // Control register field positions.
   localparam int CTRL_CH_LSB      = 2;
   localparam int CTRL_SOFT_CONVERT_BIT_POS    = 1;
   localparam int CTRL_STANDBY_POS = 0;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Register byte offsets.
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_SETTLE = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_RESULT = 5'h0C;
   // Status register field positions.
   localparam int ST_BUSY   = 0;
   localparam int ST_HOLD   = 1;
   localparam int ST_PEND   = 2;
   localparam int ST_SETTLE = 3;
   localparam int ST_EXTCLK = 4;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Conversion sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_UPDATE,
      ST_SEND
   } adcct_state_e;
endpackage : adcct_pkg

// [src/adcct_settle_timer.sv]
// Settling pulse timer that stands in for the external timing capacitor.
`timescale 1ns/1ps
`default_nettype none
module adcct_settle_timer #(
   parameter int CW = 16
) (
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          srst,
   // Pulse control.
   input  wire logic          charge,
   input  wire logic          discharge,
   input  wire logic          abort,
   input  wire logic [CW-1:0] length,
   // Pulse state.
   output logic               active
);
   logic          charging;
   logic [CW-1:0] count;
   logic          next_charging;
   logic [CW-1:0] next_count;

   // The pulse rises at the start of a write and runs out after discharge.
   always_comb begin
      next_charging = charging;
      next_count    = count;
      if (count != '0) begin
         next_count = count - 1'b1;
      end
      if (charge) begin
         next_charging = 1'b1;
      end
      if (discharge) begin
         next_charging = 1'b0;
         next_count    = length;
      end else if (abort) begin
         next_charging = 1'b0;
      end
      if (srst) begin
         next_charging = 1'b0;
         next_count    = '0;
      end
   end

   // Register the timer.
   always_ff @(posedge clock) begin
      charging <= next_charging;
      count    <= next_count;
   end

   assign active = charging | (count != '0);
endmodule : adcct_settle_timer
`default_nettype wire

// [src/adcct_sync.sv]
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module adcct_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset.
   input  wire logic         clock,
   input  wire logic         srst,
   // Pins and their synchronised copies.
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // The first stage feeds only the second stage.
   always_comb begin
      next_meta = srst ? RST_VAL : pin_in;
      next_sync = srst ? RST_VAL : meta;
   end

   // Register both stages.
   always_ff @(posedge clock) begin
      meta     <= next_meta;
      sync_out <= next_sync;
   end
endmodule : adcct_sync
`default_nettype wire

// [src/adcct_top.sv]
// Conversion timing, serial port and register slave of the converter.
`timescale 1ns/1ps
`default_nettype none
module adcct_top #(
   parameter int SETTLE_W = 16
) (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        srst,
   // AXI4-Lite write channels.
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Static mode and conversion start pins.
   input  wire logic        interface_mode_select,
   input  wire logic        convert_start_n,
   // Serial port pins.
   input  wire logic        transmit_frame_sync_n,
   input  wire logic        serial_data_in,
   input  wire logic        serial_clock_in,
   output logic             serial_clock_out,
   output logic             serial_clock_oe,
   input  wire logic        receive_frame_sync_n_in,
   output logic             receive_frame_sync_n_out,
   output logic             receive_frame_sync_n_oe,
   output logic             serial_data_out,
   output logic             serial_data_oe,
   // Converter core.
   input  wire logic [11:0] conversion_code,
   output logic             track_hold,
   output logic [2:0]       mux_channel,
   output logic             standby,
   output logic             settle_active
);
   logic [5:0] pins;
   logic       ext_mode, s_cst, s_tfs, s_din, s_sclk, s_rfs;
   logic       pv_sclk, pv_cst, pv_tfs, pv_rfs;
   logic       sclk_lvl, sclk_fall, sclk_rise, cst_rise, tfs_fall, rfs_fall;

   // Every pin passes two flip-flops before use.
   adcct_sync #(.W(6), .RST_VAL(6'h3F)) u_sync (
      .clock    (clock),
      .srst     (srst),
      .pin_in   ({interface_mode_select, convert_start_n,
                  transmit_frame_sync_n, serial_data_in,
                  serial_clock_in, receive_frame_sync_n_in}),
      .sync_out (pins)
   );
   assign {ext_mode, s_cst, s_tfs, s_din, s_sclk, s_rfs} = pins;

   // Edge detection on the synchronised levels; in self mode the serial clock edges come from serial_clock_out.
   always_ff @(posedge clock) begin
      pv_sclk <= srst ? 1'b1 : sclk_lvl;
      pv_cst  <= srst ? 1'b1 : s_cst;
      pv_tfs  <= srst ? 1'b1 : s_tfs;
      pv_rfs  <= srst ? 1'b1 : s_rfs;
   end
   assign sclk_lvl  = ext_mode ? s_sclk : serial_clock_out;
   assign sclk_fall = pv_sclk & ~sclk_lvl;
   assign sclk_rise = ~pv_sclk & sclk_lvl;
   assign cst_rise  = ~pv_cst & s_cst;
   assign tfs_fall  = pv_tfs & ~s_tfs;
   assign rfs_fall  = pv_rfs & ~s_rfs;

   // Serial write path into the control register.
   localparam int WR_LOAD_FALL = adcct_pkg::WR_LOAD_FALL;
   logic [2:0] wr_cnt, next_wr_cnt;
   logic [4:0] wr_shift, next_wr_shift;
   logic [4:0] ctrl, next_ctrl;
   logic       wr_load;

   always_comb begin
      next_wr_cnt   = wr_cnt;
      next_wr_shift = wr_shift;
      next_ctrl     = ctrl;
      wr_load       = 1'b0;
      if (tfs_fall) begin
         next_wr_cnt = 3'h0;
      end else if (!s_tfs && sclk_fall && wr_cnt < 3'(WR_LOAD_FALL)) begin
         next_wr_cnt = wr_cnt + 3'h1;
         if (wr_cnt < 3'(adcct_pkg::CTRL_BITS)) begin
            next_wr_shift = {wr_shift[3:0], s_din};
         end else begin
            next_ctrl = wr_shift;
            wr_load   = 1'b1;
         end
      end
      if (srst) begin
         next_wr_cnt   = 3'(WR_LOAD_FALL);
         next_wr_shift = 5'h00;
         next_ctrl     = adcct_pkg::CTRL_RST;
      end
   end

   always_ff @(posedge clock) begin
      wr_cnt   <= next_wr_cnt;
      wr_shift <= next_wr_shift;
      ctrl     <= next_ctrl;
   end

   // Channel follows the register at once, even mid conversion.
   assign mux_channel = ctrl[adcct_pkg::CTRL_CH_LSB +: 3];
   assign standby     = ctrl[adcct_pkg::CTRL_STANDBY_POS];

   // Settling pulse, restarted by every control write.
   logic [SETTLE_W-1:0] settle_len;
   adcct_settle_timer #(.CW(SETTLE_W)) u_settle (
      .clock     (clock),
      .srst      (srst),
      .charge    (tfs_fall),
      .discharge (wr_load),
      .abort     (~pv_tfs & s_tfs & wr_cnt < 3'(WR_LOAD_FALL)),
      .length    (settle_len),
      .active    (settle_active)
   );

   // Conversion sequencer.
   adcct_pkg::adcct_state_e state, next_state;
   logic [7:0]  cnt, next_cnt;
   logic        hw_pend, next_hw_pend, sw_pend, next_sw_pend;
   logic [15:0] result, next_result;
   logic        go, frame_done;

   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_hw_pend = hw_pend;
      next_sw_pend = sw_pend;
      next_result  = result;
      go = (state == adcct_pkg::ST_IDLE) && !standby && !settle_active &&
           (cst_rise || hw_pend || sw_pend);
      if (cst_rise && state == adcct_pkg::ST_IDLE) begin
         next_hw_pend = 1'b1;
      end
      case (state)
         adcct_pkg::ST_IDLE: begin
            if (go) begin
               next_state   = adcct_pkg::ST_CONVERT;
               next_cnt     = 8'h00;
               next_hw_pend = 1'b0;
               next_sw_pend = 1'b0;
            end
         end
         adcct_pkg::ST_CONVERT: begin
            next_cnt = cnt + 8'h01;
            if (cnt == 8'(adcct_pkg::SOFT_CONVERT_BIT_CLKS - 1)) begin
               next_state = adcct_pkg::ST_UPDATE;
            end
         end
         adcct_pkg::ST_UPDATE: begin
            next_result = {1'b0, mux_channel, conversion_code};
            next_state  = ext_mode ? adcct_pkg::ST_IDLE
                                   : adcct_pkg::ST_SEND;
         end
         adcct_pkg::ST_SEND: begin
            if (frame_done) begin
               next_state = adcct_pkg::ST_IDLE;
            end
         end
         default: next_state = adcct_pkg::ST_IDLE;
      endcase
      if (wr_load && wr_shift[adcct_pkg::CTRL_SOFT_CONVERT_BIT_POS]) begin
         next_sw_pend = 1'b1;
      end
      if (srst) begin
         next_state   = adcct_pkg::ST_IDLE;
         next_cnt     = 8'h00;
         next_hw_pend = 1'b0;
         next_sw_pend = 1'b0;
         next_result  = 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      state   <= next_state;
      cnt     <= next_cnt;
      hw_pend <= next_hw_pend;
      sw_pend <= next_sw_pend;
      result  <= next_result;
   end

   assign track_hold = (state == adcct_pkg::ST_CONVERT);

   // Output shifter and self mode clock generator.
   logic [15:0] rd_shift, next_rd_shift;
   logic [4:0]  rd_cnt, next_rd_cnt;
   logic [1:0]  div, next_div;
   logic        next_sclk, sclk_run, rd_en;

   assign sclk_run   = !ext_mode &&
                       (state == adcct_pkg::ST_SEND || !s_tfs);
   assign rd_en      = ext_mode ? !s_rfs : (state == adcct_pkg::ST_SEND);
   assign frame_done = sclk_rise &&
                       rd_cnt == 5'(adcct_pkg::FRAME_BITS - 1);

   always_comb begin
      next_rd_shift = rd_shift;
      next_rd_cnt   = rd_cnt;
      next_div      = 2'h0;
      next_sclk     = 1'b1;
      if (sclk_run || !serial_clock_out) begin // Finish a low phase.
         next_sclk = serial_clock_out;
         next_div  = div + 2'h1;
         if (div == 2'(adcct_pkg::SCLK_HALF_CLKS - 1)) begin
            next_div  = 2'h0;
            next_sclk = ~serial_clock_out;
         end
      end
      if (state == adcct_pkg::ST_UPDATE) begin
         next_rd_shift = {1'b0, mux_channel, conversion_code};
         next_rd_cnt   = 5'h00;
      end else if (ext_mode && rfs_fall &&
                   rd_cnt == 5'(adcct_pkg::FRAME_BITS)) begin
         next_rd_shift = result;
         next_rd_cnt   = 5'h00;
      end else if (rd_en && sclk_rise &&
                   rd_cnt < 5'(adcct_pkg::FRAME_BITS)) begin
         next_rd_shift = {rd_shift[14:0], 1'b0};
         next_rd_cnt   = rd_cnt + 5'h01;
      end
      if (srst) begin
         next_rd_shift = 16'h0000;
         next_rd_cnt   = 5'(adcct_pkg::FRAME_BITS);
         next_div      = 2'h0;
         next_sclk     = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      rd_shift         <= next_rd_shift;
      rd_cnt           <= next_rd_cnt;
      div              <= next_div;
      serial_clock_out <= next_sclk;
   end

   // Pin drivers: self mode drives clock and frame sync.
   assign serial_data_out          = rd_shift[15];
   assign serial_clock_oe          = !ext_mode;
   assign receive_frame_sync_n_oe  = !ext_mode;
   assign receive_frame_sync_n_out =
      (state != adcct_pkg::ST_SEND);
   assign serial_data_oe = rd_en && rd_cnt < 5'(adcct_pkg::FRAME_BITS);

   // Register slave address decode.
   function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
      hit = (a[4:2] == o[4:2]);
   endfunction : hit

   logic        aw_ok, next_aw_ok, w_ok, next_w_ok;
   logic [4:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata, status_word;
   logic [SETTLE_W-1:0] next_settle_len;

   assign s_axi_awready = !aw_ok;
   assign s_axi_wready  = !w_ok;
   assign s_axi_arready = !s_axi_rvalid;
   assign status_word   = 32'({ext_mode, settle_active, hw_pend | sw_pend,
                               track_hold, state != adcct_pkg::ST_IDLE});

   always_comb begin
      next_aw_ok      = aw_ok | s_axi_awvalid;
      next_aw_addr    = aw_ok ? aw_addr : s_axi_awaddr;
      next_w_ok       = w_ok | s_axi_wvalid;
      next_w_data     = w_ok ? w_data : s_axi_wdata;
      next_w_strb     = w_ok ? w_strb : s_axi_wstrb;
      next_bvalid     = s_axi_bvalid & ~s_axi_bready;
      next_bresp      = s_axi_bresp;
      next_settle_len = settle_len;
      next_rvalid     = s_axi_rvalid & ~s_axi_rready;
      next_rdata      = s_axi_rdata;
      next_rresp      = s_axi_rresp;
      if (aw_ok && w_ok && !s_axi_bvalid) begin
         next_aw_ok  = 1'b0;
         next_w_ok   = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = adcct_pkg::RESP_OKAY;
         if (hit(aw_addr, adcct_pkg::REG_SETTLE)) begin
            for (int b = 0; b < SETTLE_W / 8; b++) begin
               if (w_strb[b]) begin
                  next_settle_len[b*8 +: 8] = w_data[b*8 +: 8];
               end
            end
         end else if (!hit(aw_addr, adcct_pkg::REG_CTRL) &&
                      !hit(aw_addr, adcct_pkg::REG_STATUS) &&
                      !hit(aw_addr, adcct_pkg::REG_RESULT)) begin
            next_bresp = adcct_pkg::RESP_SLVERR;
         end
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
         next_rvalid = 1'b1;
         next_rresp  = adcct_pkg::RESP_OKAY;
         if (hit(s_axi_araddr, adcct_pkg::REG_CTRL)) begin
            next_rdata = 32'(ctrl);
         end else if (hit(s_axi_araddr, adcct_pkg::REG_SETTLE)) begin
            next_rdata = 32'(settle_len);
         end else if (hit(s_axi_araddr, adcct_pkg::REG_STATUS)) begin
            next_rdata = status_word;
         end else if (hit(s_axi_araddr, adcct_pkg::REG_RESULT)) begin
            next_rdata = 32'(result);
         end else begin
            next_rdata = 32'h00000000;
            next_rresp = adcct_pkg::RESP_SLVERR;
         end
      end
      if (srst) begin
         next_aw_ok      = 1'b0;
         next_aw_addr    = 5'h00;
         next_w_ok       = 1'b0;
         next_w_data     = 32'h00000000;
         next_w_strb     = 4'h0;
         next_bvalid     = 1'b0;
         next_bresp      = adcct_pkg::RESP_OKAY;
         next_settle_len = SETTLE_W'(adcct_pkg::SETTLE_CLKS);
         next_rvalid     = 1'b0;
         next_rdata      = 32'h00000000;
         next_rresp      = adcct_pkg::RESP_OKAY;
      end
   end

   always_ff @(posedge clock) begin
      aw_ok        <= next_aw_ok;
      aw_addr      <= next_aw_addr;
      w_ok         <= next_w_ok;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      settle_len   <= next_settle_len;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
   end
endmodule : adcct_top
`default_nettype wire
